// *** verilog/rfc_top.sv ***
// Receive calibration and signal-strength control: register file, RC and I/Q calibration, gain encodings.
//
// Overview of operation
// - Auto RC calibration before each receive, unless bypassed.
// - Bypass skips calibration, applies manual value.
// - Force bit starts RC calibration when idle; a force during a run is dropped.
// - Running flag high while RC calibration executes.
// - RC result readable and drives filter trim.
// - Calibration status register is read-only.
// - Two-bit trim adjusts calibration resistor reference.
// - Image start bit launches I/Q calibration.
// - I/Q running flag high during the sweep.
// - Sweep all I/Q codes, one measurement each.
// - Store code with lowest strength reading.
// - Filter gain codes give -2/17/22/27 dB.
// - LNA gain codes give 4/17/23/25.5 dB.
// - Limiter I/Q bits feed FM demodulator.
// - Strength converter produces six-bit raw value.
// - Raw strength is digitally filtered and interpolated.
// - Filter select N sets cutoff fref/(2pi*2^(5+N)).
// - Receive start waits for calibration before enabling.
// - Low gain adds compensation to strength result.
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "rfc_params.svh"
module rfc_top #(
  parameter int RC_STEP_CYCLES = `RFC_RC_CAL_STEP_CYCLES,
  parameter int IQ_SETTLE_CYCLES = `RFC_IMAGE_SETTLE_CYCLES,
  parameter int SAMPLE_CYCLES = `RFC_STRENGTH_SAMPLE_CYCLES
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Register port.
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Analog front-end pins.
  input wire logic rc_cmp_pin,
  input wire logic lim_i_pin,
  input wire logic lim_q_pin,
  input wire logic [5:0] strength_raw_pin,
  // Controls to the analog receive chain.
  output logic [3:0] filter_rc_trim,
  output logic [1:0] filter_r_trim,
  output logic [6:0] image_trim,
  output logic [1:0] filter_gain,
  output logic [1:0] lna_gain,
  output logic rx_enable,
  // Digitised limiter outputs to the demodulator.
  output logic demod_i,
  output logic demod_q
);
  import rfc_pkg::*;

  // ==========================================================
  // Gain encodings in tenths of a decibel, for readback.
  function automatic logic [8:0] filter_gain_db10(input logic [1:0] code);
    case (code)
      2'b00: filter_gain_db10 = 9'h1EC; // -2.0 dB, two's complement.
      2'b01: filter_gain_db10 = 9'h0AA;
      2'b10: filter_gain_db10 = 9'h0DC;
      default: filter_gain_db10 = 9'h10E;
    endcase
  endfunction

  function automatic logic [8:0] lna_gain_db10(input logic [1:0] code);
    case (code)
      2'b00: lna_gain_db10 = 9'h028;
      2'b01: lna_gain_db10 = 9'h0AA;
      2'b10: lna_gain_db10 = 9'h0E6;
      default: lna_gain_db10 = 9'h0FF;
    endcase
  endfunction

  // ==========================================================
  // Pin synchronisers.
  logic [1:0] cmp_s1_q, cmp_s2_q;
  logic [1:0] lim_s1_q, lim_s2_q;
  logic [5:0] raw_s1_q, raw_s2_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmp_s1_q <= 2'h0;
      cmp_s2_q <= 2'h0;
      lim_s1_q <= 2'h0;
      lim_s2_q <= 2'h0;
      raw_s1_q <= 6'h00;
      raw_s2_q <= 6'h00;
    end else begin
      cmp_s1_q <= {1'b0, rc_cmp_pin};
      cmp_s2_q <= cmp_s1_q;
      lim_s1_q <= {lim_q_pin, lim_i_pin};
      lim_s2_q <= lim_s1_q;
      raw_s1_q <= strength_raw_pin;
      raw_s2_q <= raw_s1_q;
    end
  end
  // Limiter outputs are one-bit square waves sent straight on.
  assign demod_i = lim_s2_q[0];
  assign demod_q = lim_s2_q[1];
  // Six-bit raw converter value.
  wire rfc_strength_t raw_strength = raw_s2_q;

  // ==========================================================
  // Register file.
  logic bypass_q, force_q, img_start_q;
  logic [1:0] trim_q;
  logic [3:0] manual_q;
  logic [6:0] img_value_q;
  logic [3:0] lpf_sel_q;
  logic [1:0] cf_gain_q, lna_gain_q;
  logic [6:0] comp_q;
  logic rx_req_q, low_gain_q;
  logic [15:0] rdata_q;

  wire wr_ovr = reg_wr && reg_addr == `RFC_ADDR_OVERRIDE;
  wire wr_img = reg_wr && reg_addr == `RFC_ADDR_IMAGE;
  wire wr_bw = reg_wr && reg_addr == `RFC_ADDR_BANDWIDTH;
  wire wr_gain = reg_wr && reg_addr == `RFC_ADDR_GAIN;
  wire wr_comp = reg_wr && reg_addr == `RFC_ADDR_COMP;
  wire wr_ctl = reg_wr && reg_addr == `RFC_ADDR_CONTROL;

  rfc_rc_state_e rc_state;
  logic [3:0] rc_result, rc_trial;
  logic [6:0] iq_best_q, iq_best_next;
  logic iq_done;
  logic [7:0] level;
  wire rc_active = (rc_state == RFC_RC_RUN);
  wire iq_active;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bypass_q <= 1'b0;
      force_q <= 1'b0;
      trim_q <= 2'h0;
      manual_q <= `RFC_RST_RESULT;
      img_start_q <= 1'b0;
      img_value_q <= 7'h00;
      lpf_sel_q <= `RFC_RST_BANDWIDTH;
      cf_gain_q <= 2'h0;
      lna_gain_q <= 2'h0;
      comp_q <= 7'h00;
      rx_req_q <= 1'b0;
      low_gain_q <= 1'b0;
    end else begin
      if (wr_ovr) begin
        bypass_q <= reg_wdata[`RFC_OVR_BYPASS];
        trim_q <= reg_wdata[`RFC_OVR_TRIM_LO +: 2];
        // Software keeps the manual value for bypass use.
        manual_q <= reg_wdata[`RFC_OVR_MAN_LO +: 4];
      end
      // Force is a self-clearing request bit.
      force_q <= wr_ovr && reg_wdata[`RFC_OVR_FORCE];
      img_start_q <= wr_img && reg_wdata[`RFC_IMG_START];
      // Sweep result wins over a software write in the same cycle.
      if (iq_done) begin
        img_value_q <= iq_best_next;
      end else if (wr_img) begin
        img_value_q <= reg_wdata[6:0];
      end
      if (wr_bw) lpf_sel_q <= reg_wdata[3:0];
      if (wr_gain) begin
        cf_gain_q <= reg_wdata[`RFC_GAIN_CF_LO +: 2];
        lna_gain_q <= reg_wdata[`RFC_GAIN_LNA_LO +: 2];
      end
      if (wr_comp) comp_q <= reg_wdata[6:0];
      if (wr_ctl) begin
        rx_req_q <= reg_wdata[`RFC_CTL_RX_REQ];
        low_gain_q <= reg_wdata[`RFC_CTL_LOW_GAIN];
      end
    end
  end

  // Status register has no write decode, so writes do nothing.
  // Result and running flag are readable.
  wire [15:0] status_word = {11'h000, rc_active, rc_result};
  wire [15:0] image_word = {7'h00, iq_active, 1'b0, img_value_q};
  wire [15:0] ovr_word = {8'h00, manual_q, trim_q, 1'b0, bypass_q};
  // Gain register reads back both codes and the LNA gain in tenths of a dB; the filter gain reads back in the compensation register.
  wire [8:0] lna_db10 = lna_gain_db10(lna_gain_q);
  wire [15:0] gain_word = {3'h0, lna_db10, lna_gain_q, cf_gain_q};
  wire [15:0] gdb_word = {7'h00, filter_gain_db10(cf_gain_q)};
  wire [15:0] ctl_word = {13'h0000, rx_enable, low_gain_q, rx_req_q};
  wire [15:0] rd_mux =
    (reg_addr == `RFC_ADDR_OVERRIDE) ? ovr_word :
    (reg_addr == `RFC_ADDR_STATUS) ? status_word :
    (reg_addr == `RFC_ADDR_IMAGE) ? image_word :
    (reg_addr == `RFC_ADDR_BANDWIDTH) ? {12'h000, lpf_sel_q} :
    (reg_addr == `RFC_ADDR_GAIN) ? gain_word :
    (reg_addr == `RFC_ADDR_COMP) ? {gdb_word[8:0], comp_q} :
    (reg_addr == `RFC_ADDR_STRENGTH) ? {8'h00, level} :
    (reg_addr == `RFC_ADDR_CONTROL) ? ctl_word : 16'h0000;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= reg_rd ? rd_mux : 16'h0000;
    end
  end
  assign reg_rdata = rdata_q;

  // ==========================================================
  // RC calibration launch and receive enable.
  logic rx_req_d1_q, rx_on_q, rx_wait_q;
  wire rx_rise = rx_req_q && !rx_req_d1_q;
  wire auto_start = rx_rise && !bypass_q;
  // Starts are only taken while idle, so a force during a run is dropped.
  wire rc_start = (force_q || auto_start) && rc_state == RFC_RC_IDLE;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_req_d1_q <= 1'b0;
      rx_on_q <= 1'b0;
      rx_wait_q <= 1'b0;
    end else begin
      rx_req_d1_q <= rx_req_q;
      if (!rx_req_q) begin
        rx_on_q <= 1'b0;
        rx_wait_q <= 1'b0;
      end else if (rx_rise) begin
        rx_on_q <= bypass_q;
        rx_wait_q <= !bypass_q;
      end else if (rx_wait_q && rc_state == RFC_RC_DONE) begin
        // Receiver is turned on only once calibration has finished.
        rx_on_q <= 1'b1;
        rx_wait_q <= 1'b0;
      end
    end
  end
  assign rx_enable = rx_on_q;

  rfc_rc_cal #(
    .STEP_CYCLES(RC_STEP_CYCLES)
  ) u_rc_cal (
    .clk(clk),
    .sys_rst(sys_rst),
    .start(rc_start),
    .r_trim(trim_q),
    .rc_too_slow(cmp_s2_q[0]),
    .state(rc_state),
    .result(rc_result),
    .trial(rc_trial),
    .trim_out(filter_r_trim)
  );

  // Trial code during a run, manual value under bypass, else result.
  assign filter_rc_trim = rc_active ? rc_trial : (bypass_q ? manual_q : rc_result);
  assign filter_gain = cf_gain_q;
  assign lna_gain = lna_gain_q;

  // ==========================================================
  // Signal-strength sampling and filtering.
  logic [7:0] samp_cnt_q;
  wire samp_tick = (samp_cnt_q == 8'(SAMPLE_CYCLES - 1));
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      samp_cnt_q <= 8'h00;
    end else begin
      samp_cnt_q <= samp_tick ? 8'h00 : samp_cnt_q + 8'h01;
    end
  end

  rfc_strength_lpf u_lpf (
    .clk(clk),
    .sys_rst(sys_rst),
    .sample_en(samp_tick),
    .raw(raw_strength),
    .low_gain(low_gain_q),
    .gain_comp(comp_q),
    .lpf_select(lpf_sel_q),
    .level(level)
  );

  // ==========================================================
  // I/Q image-rejection sweep.
  rfc_iq_state_e iq_state_q, iq_state_d;
  logic [6:0] iq_code_q;
  logic [5:0] iq_min_q;
  logic [7:0] iq_wait_q;
  wire iq_settled = (iq_wait_q == 8'(IQ_SETTLE_CYCLES - 1));
  wire iq_last = (iq_code_q == 7'h7F);
  assign iq_active = (iq_state_q != RFC_IQ_IDLE);
  assign iq_done = (iq_state_q == RFC_IQ_MEASURE) && samp_tick && iq_last;
  wire iq_better = raw_strength < iq_min_q || iq_code_q == 7'h00;
  // The last code's own measurement must count when the result is stored.
  assign iq_best_next = iq_better ? iq_code_q : iq_best_q;

  always_comb begin
    iq_state_d = iq_state_q;
    case (iq_state_q)
      RFC_IQ_IDLE: if (img_start_q) iq_state_d = RFC_IQ_SETTLE;
      RFC_IQ_SETTLE: if (iq_settled) iq_state_d = RFC_IQ_MEASURE;
      RFC_IQ_MEASURE: if (samp_tick) iq_state_d = iq_last ? RFC_IQ_IDLE : RFC_IQ_SETTLE;
      default: iq_state_d = RFC_IQ_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      iq_state_q <= RFC_IQ_IDLE;
      iq_code_q <= 7'h00;
      iq_min_q <= 6'h3F;
      iq_best_q <= 7'h00;
      iq_wait_q <= 8'h00;
    end else begin
      iq_state_q <= iq_state_d;
      if (iq_state_q == RFC_IQ_IDLE) begin
        iq_code_q <= 7'h00;
        iq_min_q <= 6'h3F;
        iq_wait_q <= 8'h00;
      end else if (iq_state_q == RFC_IQ_SETTLE) begin
        iq_wait_q <= iq_settled ? 8'h00 : iq_wait_q + 8'h01;
      end else if (samp_tick) begin
        // One measurement per code, keeping the minimum.
        if (iq_better) begin
          iq_min_q <= raw_strength;
          iq_best_q <= iq_code_q;
        end
        iq_code_q <= iq_code_q + 7'h01;
      end
    end
  end
  // Sweep code drives the trim while active, stored value otherwise.
  assign image_trim = iq_active ? iq_code_q : img_value_q;
endmodule
`default_nettype wire

// *** verilog/rfc_params.svh ***
// Register offsets, field positions, reset values and timing counts of the receive calibration block.
`ifndef RFC_PARAMS_SVH
`define RFC_PARAMS_SVH
// ==========================================================
// Register offsets
`define RFC_ADDR_OVERRIDE 4'h0
`define RFC_ADDR_STATUS 4'h1
`define RFC_ADDR_IMAGE 4'h2
`define RFC_ADDR_BANDWIDTH 4'h3
`define RFC_ADDR_GAIN 4'h4
`define RFC_ADDR_COMP 4'h5
`define RFC_ADDR_STRENGTH 4'h6
`define RFC_ADDR_CONTROL 4'h7
// ==========================================================
// Field positions
`define RFC_OVR_BYPASS 0
`define RFC_OVR_FORCE 1
`define RFC_OVR_TRIM_LO 2
`define RFC_OVR_MAN_LO 4
`define RFC_STS_ACTIVE 4
`define RFC_IMG_START 7
`define RFC_IMG_ACTIVE 8
`define RFC_GAIN_CF_LO 0
`define RFC_GAIN_LNA_LO 2
`define RFC_CTL_RX_REQ 0
`define RFC_CTL_LOW_GAIN 1
`define RFC_CTL_RX_ON 2
// ==========================================================
// Reset values and timing
`define RFC_RST_RESULT 4'h8
`define RFC_RST_BANDWIDTH 4'h0
`define RFC_RC_CAL_STEP_CYCLES 8
`define RFC_IMAGE_SETTLE_CYCLES 16
`define RFC_STRENGTH_SAMPLE_CYCLES 32
`endif

// *** verilog/rfc_pkg.sv ***
// Types shared by the receive calibration block.
package rfc_pkg;
  typedef enum logic [1:0] {
    RFC_RC_IDLE = 2'b00,
    RFC_RC_RUN = 2'b01,
    RFC_RC_DONE = 2'b11
  } rfc_rc_state_e;
  typedef enum logic [1:0] {
    RFC_IQ_IDLE = 2'b00,
    RFC_IQ_SETTLE = 2'b01,
    RFC_IQ_MEASURE = 2'b11
  } rfc_iq_state_e;
  typedef logic [5:0] rfc_strength_t;
  typedef logic [6:0] rfc_iq_code_t;
endpackage

// *** verilog/rfc_rc_cal.sv ***
// Successive-approximation channel filter RC calibration engine.
`timescale 1ns/1ps
`default_nettype none
`include "rfc_params.svh"
module rfc_rc_cal #(
  parameter int STEP_CYCLES = `RFC_RC_CAL_STEP_CYCLES
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Control.
  input wire logic start,
  input wire logic [1:0] r_trim,
  // Comparator from the reference RC, already synchronised.
  input wire logic rc_too_slow,
  // Results.
  output var rfc_pkg::rfc_rc_state_e state,
  output logic [3:0] result,
  output logic [3:0] trial,
  output logic [1:0] trim_out
);
  import rfc_pkg::*;
  rfc_rc_state_e state_q, state_d;
  logic [3:0] result_q;
  logic [3:0] bit_q;
  logic [7:0] wait_q;
  wire step_done = (wait_q == 8'(STEP_CYCLES - 1));
  wire [3:0] try_code = result_q | bit_q;
  assign state = state_q;
  assign result = result_q;
  assign trial = try_code;
  // The resistor trim shifts the reference, so the result moves with it.
  assign trim_out = r_trim;
  always_comb begin
    state_d = state_q;
    case (state_q)
      RFC_RC_IDLE: if (start) state_d = RFC_RC_RUN;
      RFC_RC_RUN: if (step_done && bit_q == 4'h1) state_d = RFC_RC_DONE;
      RFC_RC_DONE: state_d = RFC_RC_IDLE;
      default: state_d = RFC_RC_IDLE;
    endcase
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= RFC_RC_IDLE;
      result_q <= 4'h0;
      bit_q <= 4'h8;
      wait_q <= 8'h00;
    end else begin
      state_q <= state_d;
      if (state_q == RFC_RC_IDLE && start) begin
        result_q <= 4'h0;
        bit_q <= 4'h8;
        wait_q <= 8'h00;
      end else if (state_q == RFC_RC_RUN) begin
        wait_q <= step_done ? 8'h00 : wait_q + 8'h01;
        if (step_done) begin
          if (!rc_too_slow) result_q <= try_code;
          bit_q <= bit_q >> 1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** verilog/rfc_strength_lpf.sv ***
// Signal-strength gain compensation and selectable first-order digital low-pass.
`timescale 1ns/1ps
`default_nettype none
`include "rfc_params.svh"
module rfc_strength_lpf #(
  parameter int ACC_W = 28
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Raw converter sample.
  input wire logic sample_en,
  input wire rfc_pkg::rfc_strength_t raw,
  // Settings.
  input wire logic low_gain,
  input wire logic [6:0] gain_comp,
  input wire logic [3:0] lpf_select,
  // Filtered value.
  output logic [7:0] level
);
  import rfc_pkg::*;
  logic [ACC_W-1:0] acc_q;
  // Low front-end gain adds the gain-step compensation.
  wire [7:0] comp = low_gain ? {1'b0, gain_comp} : 8'h00;
  wire [7:0] sum = 8'({2'b00, raw}) + comp;
  wire [ACC_W-1:0] target = {sum, {(ACC_W - 8){1'b0}}};
  // Shift of 5+N gives a cutoff of fref over 2 pi times 2 to the 5+N.
  wire [4:0] shift = 5'(lpf_select) + 5'd5;
  wire [ACC_W-1:0] delta_up = (target - acc_q) >> shift;
  wire [ACC_W-1:0] delta_dn = (acc_q - target) >> shift;
  assign level = acc_q[ACC_W-1 -: 8];
  // Raw value is filtered and interpolated into the reported result.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      acc_q <= '0;
    end else if (sample_en) begin
      acc_q <= (target >= acc_q) ? acc_q + delta_up : acc_q - delta_dn;
    end
  end
endmodule
`default_nettype wire

// *** testbench/rfc_top_sva.sv ***
// Port-level assertions for the receive calibration block.
`timescale 1ns/1ps
`default_nettype none
`include "rfc_params.svh"
module rfc_top_sva (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Register port.
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // Front end and receive chain.
  input wire logic lim_i_pin,
  input wire logic lim_q_pin,
  input wire logic [3:0] filter_rc_trim,
  input wire logic [1:0] filter_r_trim,
  input wire logic [6:0] image_trim,
  input wire logic [1:0] filter_gain,
  input wire logic [1:0] lna_gain,
  input wire logic rx_enable,
  input wire logic demod_i,
  input wire logic demod_q
);
  logic [1:0] age_q;
  wire wr_ovr = reg_wr && reg_addr == `RFC_ADDR_OVERRIDE;
  wire wr_gain = reg_wr && reg_addr == `RFC_ADDR_GAIN;
  wire wr_ctl = reg_wr && reg_addr == `RFC_ADDR_CONTROL;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Counts edges since reset so the limiter pipeline is only judged once filled.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) age_q <= 2'h0;
    else if (age_q != 2'h3) age_q <= age_q + 2'h1;
  end
  // ==========================================================
  // Assertions
  AST_RDATA_QUIET: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside read cycle");
  AST_DEMOD_I: assert property (age_q >= 2'h2 |-> demod_i == $past(lim_i_pin, 2))
    else $error("demod_i does not follow limiter I");
  AST_DEMOD_Q: assert property (age_q >= 2'h2 |-> demod_q == $past(lim_q_pin, 2))
    else $error("demod_q does not follow limiter Q");
  AST_TRIM_WRITE: assert property (wr_ovr |=> filter_r_trim == $past(reg_wdata[3:2]))
    else $error("resistor trim not taken from write");
  AST_TRIM_HOLD: assert property (!wr_ovr |=> $stable(filter_r_trim))
    else $error("resistor trim changed without write");
  AST_GAIN_WRITE: assert property (wr_gain |=> {lna_gain, filter_gain} == $past(reg_wdata[3:0]))
    else $error("gain codes not taken from write");
  AST_GAIN_HOLD: assert property (!wr_gain |=> $stable({lna_gain, filter_gain}))
    else $error("gain codes changed without write");
  AST_RX_OFF: assert property (wr_ctl && !reg_wdata[0] |-> ##[1:2] !rx_enable)
    else $error("receiver stays on after request cleared");
  COV_RX_ON: cover property ($rose(rx_enable));
  COV_IMAGE_TOP: cover property (image_trim == 7'h7F);
  COV_RC_TRIM: cover property ($changed(filter_rc_trim));
endmodule
bind rfc_top rfc_top_sva chk_u (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .lim_i_pin(lim_i_pin), .lim_q_pin(lim_q_pin),
  .filter_rc_trim(filter_rc_trim), .filter_r_trim(filter_r_trim), .image_trim(image_trim),
  .filter_gain(filter_gain), .lna_gain(lna_gain), .rx_enable(rx_enable), .demod_i(demod_i), .demod_q(demod_q));
`default_nettype wire

// *** testbench/rfc_top_tb.sv ***
// Register-level testbench of the receive calibration block.
`timescale 1ns/1ps
`default_nettype none
module rfc_top_tb;
  import rfc_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic rc_cmp_pin = 1'b0;
  logic lim_i_pin = 1'b0;
  logic lim_q_pin = 1'b0;
  logic [5:0] strength_raw_pin = 6'h20;
  logic [3:0] filter_rc_trim;
  logic [1:0] filter_r_trim, filter_gain, lna_gain;
  logic [6:0] image_trim;
  logic rx_enable, demod_i, demod_q;
  logic sweeping = 1'b0;
  logic [127:0] seen_codes = '0;
  int num_errors = 0;
  int checked = 0;
  rfc_top #(.RC_STEP_CYCLES(8), .IQ_SETTLE_CYCLES(8), .SAMPLE_CYCLES(4)) dut_u (.clk(clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rc_cmp_pin(rc_cmp_pin), .lim_i_pin(lim_i_pin), .lim_q_pin(lim_q_pin), .strength_raw_pin(strength_raw_pin),
    .filter_rc_trim(filter_rc_trim), .filter_r_trim(filter_r_trim), .image_trim(image_trim),
    .filter_gain(filter_gain), .lna_gain(lna_gain), .rx_enable(rx_enable), .demod_i(demod_i), .demod_q(demod_q));
  initial begin
    forever #10 clk = ~clk;
  end
  // ==========================================================
  // Analog front-end stand-in: the RC reference moves with the resistor trim.
  always @(posedge clk) begin
    rc_cmp_pin <= filter_rc_trim > (4'h5 + {2'b00, filter_r_trim});
    strength_raw_pin <= (image_trim == 7'h2A) ? 6'h03 : (image_trim == 7'h55) ? 6'h04 : 6'h20;
    lim_i_pin <= ~lim_i_pin;
    lim_q_pin <= lim_i_pin;
    if (sweeping) seen_codes[image_trim] <= 1'b1;
  end
  // ==========================================================
  // Bus tasks and comparison.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #5 d = reg_rdata;
    @(posedge clk);
  endtask
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wait_idle(input logic [3:0] a, input int bitpos, output int n);
    logic [15:0] d;
    n = 0;
    do begin
      rd(a, d);
      n = n + 2;
    end while (d[bitpos] !== 1'b0 && n < 5000);
    chk("busy_ends", n < 5000, 1'b1);
  endtask
  task automatic rc_force(input logic [1:0] t, input logic again);
    logic [15:0] d;
    logic [3:0] e;
    int n;
    e = 4'h5 + {2'b00, t};
    wr(4'h0, {12'h000, t, 2'b10});
    rd(4'h1, d);
    chk("rc_active", d[4], 1'b1);
    if (again) begin
      cyc(8);
      wr(4'h0, {12'h000, t, 2'b10});
    end
    wait_idle(4'h1, 4, n);
    if (again) chk("rc_no_restart", n <= 28, 1'b1);
    rd(4'h1, d);
    chk("rc_result", d, {12'h000, e});
    #5 chk("rc_trim_pin", filter_rc_trim, e);
    cyc(1);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #600000;
    num_errors++;
    stop_test();
  end
  // ==========================================================
  // Test sequence.
  initial begin
    logic [15:0] d, d0;
    int n;
    static int lna_db[4] = '{40, 170, 230, 255};
    static int cf_db[4] = '{-20, 170, 220, 270};
    cyc(3);
    sys_rst <= 1'b0;
    cyc(1);
    rd(4'h0, d);
    chk("override_reset", d, 16'h0080);
    rd(4'hA, d);
    chk("unmapped_read", d, 16'h0000);
    rd(4'h1, d0);
    wr(4'h1, 16'hFFFF);
    rd(4'h1, d);
    chk("status_read_only", d, d0);
    $display("test reset done");
    rc_force(2'h0, 1'b0);
    rc_force(2'h2, 1'b1);
    $display("test force done");
    wr(4'h0, 16'h0091);
    #5 chk("bypass_trim_pin", filter_rc_trim, 4'h9);
    cyc(1);
    wr(4'h7, 16'h0001);
    cyc(2);
    #5 chk("bypass_rx_on", rx_enable, 1'b1);
    cyc(1);
    rd(4'h1, d);
    chk("bypass_no_cal", d[4], 1'b0);
    rd(4'h0, d);
    chk("override_keep", d, 16'h0091);
    wr(4'h7, 16'h0000);
    #5 chk("rx_off", rx_enable, 1'b0);
    cyc(1);
    $display("test bypass done");
    wr(4'h0, 16'h0000);
    wr(4'h7, 16'h0001);
    rd(4'h1, d);
    chk("auto_cal_runs", d[4], 1'b1);
    #5 chk("rx_waits", rx_enable, 1'b0);
    cyc(1);
    wait_idle(4'h1, 4, n);
    cyc(2);
    #5 chk("rx_after_cal", rx_enable, 1'b1);
    cyc(1);
    rd(4'h1, d);
    chk("auto_result", d, 16'h0005);
    wr(4'h7, 16'h0000);
    $display("test receive start done");
    sweeping <= 1'b1;
    wr(4'h2, 16'h0080);
    rd(4'h2, d);
    chk("image_active", d[8], 1'b1);
    wait_idle(4'h2, 8, n);
    sweeping <= 1'b0;
    rd(4'h2, d);
    chk("image_min_code", d, 16'h002A);
    chk("image_all_codes", $countones(seen_codes), 16'd128);
    wr(4'h2, 16'h0000);
    rd(4'h2, d);
    chk("image_cleared", d, 16'h0000);
    #5 chk("image_pin", image_trim, 7'h00);
    cyc(1);
    $display("test image sweep done");
    wr(4'h3, 16'h0000);
    wr(4'h5, 16'h0010);
    cyc(3000);
    rd(4'h6, d);
    chk("level_settled", d >= 16'h001E && d <= 16'h0020, 1'b1);
    wr(4'h3, 16'h0003);
    rd(4'h6, d0);
    wr(4'h7, 16'h0002);
    cyc(64);
    rd(4'h6, d);
    chk("level_slow", d >= d0 && d - d0 <= 16'h0002, 1'b1);
    wr(4'h3, 16'h0000);
    cyc(3000);
    rd(4'h6, d);
    chk("level_low_gain", d >= 16'h002E && d <= 16'h0030, 1'b1);
    $display("test strength done");
    for (int i = 0; i < 4; i++) begin
      wr(4'h4, {12'h000, 2'(i), 2'(i)});
      rd(4'h4, d);
      chk("lna_code_db", d, {3'b000, 9'(lna_db[i]), 2'(i), 2'(i)});
      rd(4'h5, d);
      chk("cf_code_db", d, {9'(cf_db[i]), 7'h10});
      #5 chk("gain_pins", {lna_gain, filter_gain}, {2'(i), 2'(i)});
      cyc(1);
    end
    $display("test gain table done");
    stop_test();
  end
endmodule
`default_nettype wire
